// ---- smc_top.sv ----
// standby mode controller: mode sequencer, clock gating, wake logic, AXI4-Lite
// assumes core and interrupt controller signals synchronous to aclk
`timescale 1ns/1ns
module smc_top #(
  parameter int WU_LEN_MID  = 16384,
  parameter int WU_LEN_LONG = 65536
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // processor core
  input  wire logic        wait_exec,
  input  wire logic        reduced_power_select,
  input  wire logic        cpu_irq_accept,
  input  wire logic [7:0]  irq_mask_level,
  output logic             resume_pulse,
  output logic             take_irq,
  // interrupt controller
  input  wire logic [7:0]  irq_level,
  input  wire logic        nmi_req,
  input  wire logic        ext_pin_irqs,
  input  wire logic        key_wakeup,
  input  wire logic        rtc_irq,
  input  wire logic        pulse_counter_irqs,
  input  wire logic        general_timer_irqs,
  input  wire logic        watchdog_irq,
  input  wire logic        serial_irq,
  input  wire logic        two_wire_serial_irq,
  input  wire logic        converter_irq,
  // dma bus ownership
  input  wire logic        dma_bus_req,
  output logic             dma_bus_grant,
  // oscillator ticks for warm-up counting
  input  wire logic        hs_osc_tick,
  input  wire logic        ls_osc_tick,
  // clock generator controls
  output logic             hs_osc_run,
  output logic             ls_osc_run,
  output logic             pll_run,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             irq_controller_clk_en,
  output logic             ebi_io_clk_en,
  output logic             dma_clk_en,
  output logic             keep_alive_clk_en,
  output logic             rtc_clk_en,
  output logic             pin_drive_en
);
  import smc_pkg::*;

  // ==========================================================
  // registers and state
  logic [7:0] ctrl_q, ctrl_d;          // control register
  smc_mode_t  mode_q, mode_d;          // operating mode
  logic       prev_slow_q, prev_slow_d; // return target after warm-up/standby
  logic       hs_off_q, hs_off_d;      // oscillator was stopped in SLOW
  logic       doze_q, doze_d;          // IDLE variant
  logic       resume_q, resume_d;      // resume pulse to core
  logic       take_q, take_d;          // take-interrupt pulse to core
  logic       wu_start;                // load warm-up counter
  logic [1:0] wu_sel;                  // chosen length
  logic       wu_tick;                 // ticks of restarted oscillator
  logic       wu_busy;                 // counter running
  logic       wu_done;                 // counter finished

  // bus state
  logic       aw_hold_q, aw_hold_d;    // write address captured
  logic       w_hold_q, w_hold_d;      // write data captured
  logic [7:0] awaddr_q, awaddr_d;      // captured write address
  logic [7:0] wdata_q, wdata_d;        // captured low data byte
  logic       wstrb0_q, wstrb0_d;      // low byte lane enabled
  logic       bvalid_q, bvalid_d;      // write response pending
  logic [1:0] bresp_q, bresp_d;        // write response code
  logic       rvalid_q, rvalid_d;      // read data pending
  logic [1:0] rresp_q, rresp_d;        // read response code
  logic [31:0] rdata_q, rdata_d;       // read data

  // control fields
  logic [1:0] type_sel;
  logic [1:0] warmup_select;
  logic       hs_osc_enable;
  logic       drive_enable;
  logic       slow_req;
  logic       pcnt_mode;

  assign type_sel      = ctrl_q[SMC_CTRL_TYPE_LSB +: 2];
  assign warmup_select = ctrl_q[SMC_CTRL_WU_LSB +: 2];
  assign hs_osc_enable = ctrl_q[SMC_CTRL_HSEN_BIT];
  assign drive_enable  = ctrl_q[SMC_CTRL_DRVE_BIT];
  assign slow_req      = ctrl_q[SMC_CTRL_SLOW_BIT];
  assign pcnt_mode     = ctrl_q[SMC_CTRL_PCNT_BIT];

  // ==========================================================
  // wake sources
  logic any_src;     // some request allowed by the current mode
  logic above_mask;  // strictly above mask
  logic at_mask;     // at or above mask
  logic wake;        // release condition
  logic warm_src;    // wake came from pins or keys

  // per-mode release source selection
  always_comb begin
    case (mode_q)
      SMC_IDLE: begin
        any_src = ext_pin_irqs | key_wakeup | rtc_irq | pulse_counter_irqs |
                  general_timer_irqs | watchdog_irq | serial_irq |
                  two_wire_serial_irq | converter_irq;
      end
      SMC_SLEEP: begin
        any_src = ext_pin_irqs | key_wakeup | rtc_irq | (pulse_counter_irqs & pcnt_mode);
      end
      SMC_STOP: begin
        any_src = ext_pin_irqs | key_wakeup;
      end
      default: begin
        any_src = 1'b0;
      end
    endcase
  end

  assign above_mask = irq_level > irq_mask_level;
  assign at_mask    = irq_level >= irq_mask_level;
  assign wake       = nmi_req | (any_src & above_mask);
  assign warm_src   = ext_pin_irqs | key_wakeup;

  // ==========================================================
  // mode sequencer
  // reset lands in NORMAL from any mode
  always_comb begin
    mode_d      = mode_q;
    prev_slow_d = prev_slow_q;
    hs_off_d    = hs_off_q;
    doze_d      = doze_q;
    resume_d    = 1'b0;
    take_d      = 1'b0;
    wu_start    = 1'b0;
    wu_sel      = warmup_select;
    case (mode_q)
      SMC_NORMAL, SMC_SLOW: begin
        if (mode_q == SMC_SLOW && !hs_osc_enable) begin
          hs_off_d = 1'b1;
        end
        if (wait_exec && type_sel != SMC_TYPE_RSVD) begin
          prev_slow_d = (mode_q == SMC_SLOW);
          if (type_sel == SMC_TYPE_IDLE) begin
            mode_d = SMC_IDLE;
            doze_d = reduced_power_select;
          end else if (!reduced_power_select) begin
            mode_d = (type_sel == SMC_TYPE_STOP) ? SMC_STOP : SMC_SLEEP;
          end
        end else if (mode_q == SMC_NORMAL && slow_req) begin
          mode_d = SMC_SLOW;
        end else if (mode_q == SMC_SLOW && !slow_req) begin
          if (hs_off_q || !hs_osc_enable) begin
            prev_slow_d = 1'b0;
            wu_start    = 1'b1;
            mode_d      = SMC_WARMUP;
          end else begin
            mode_d = SMC_NORMAL;
          end
        end
      end
      SMC_IDLE: begin
        if (wake) begin
          mode_d   = prev_slow_q ? SMC_SLOW : SMC_NORMAL;
          resume_d = 1'b1;
          take_d   = nmi_req | (cpu_irq_accept & at_mask);
        end
      end
      SMC_SLEEP: begin
        if (wake) begin
          if (prev_slow_q) begin
            mode_d   = SMC_SLOW;
            resume_d = 1'b1;
            take_d   = nmi_req | (cpu_irq_accept & at_mask);
          end else begin
            wu_start = 1'b1;
            mode_d   = SMC_WARMUP;
          end
        end
      end
      SMC_STOP: begin
        if (wake && (warm_src || nmi_req)) begin
          wu_start = 1'b1;
          mode_d   = SMC_WARMUP;
        end
      end
      SMC_WARMUP: begin
        if (wu_done) begin
          mode_d   = prev_slow_q ? SMC_SLOW : SMC_NORMAL;
          resume_d = 1'b1;
          take_d   = nmi_req | (cpu_irq_accept & at_mask);
          hs_off_d = 1'b0;
        end
      end
      default: begin
        mode_d = SMC_NORMAL;
      end
    endcase
    if (mode_d == SMC_NORMAL) begin
      hs_off_d = 1'b0;
    end
  end

  // oscillator being restarted decides the tick source
  assign wu_tick = prev_slow_q ? ls_osc_tick : hs_osc_tick;

  // warm-up counter
  smc_warmup #(
    .LEN_MID  (WU_LEN_MID),
    .LEN_LONG (WU_LEN_LONG)
  ) u_warmup (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (wu_start),
    .sel      (wu_sel),
    .osc_tick (wu_tick),
    .busy     (wu_busy),
    .done     (wu_done)
  );

  // ==========================================================
  // clock gating per mode
  always_comb begin
    hs_osc_run        = 1'b0;
    ls_osc_run        = 1'b1;
    pll_run           = 1'b0;
    cpu_clk_en        = 1'b0;
    periph_clk_en     = 1'b0;
    irq_controller_clk_en       = 1'b0;
    ebi_io_clk_en     = 1'b0;
    dma_clk_en        = 1'b0;
    keep_alive_clk_en = 1'b1;
    rtc_clk_en        = 1'b1;
    pin_drive_en      = 1'b1;
    case (mode_q)
      SMC_NORMAL: begin
        hs_osc_run    = 1'b1;
        pll_run       = 1'b1;
        cpu_clk_en    = 1'b1;
        periph_clk_en = 1'b1;
        irq_controller_clk_en   = 1'b1;
        ebi_io_clk_en = 1'b1;
        dma_clk_en    = 1'b1;
      end
      SMC_SLOW: begin
        hs_osc_run    = hs_osc_enable;
        cpu_clk_en    = 1'b1;
        irq_controller_clk_en   = 1'b1;
        ebi_io_clk_en = 1'b1;
      end
      SMC_IDLE: begin
        hs_osc_run    = 1'b1;
        pll_run       = 1'b1;
        periph_clk_en = 1'b1;
        dma_clk_en    = 1'b1;
        irq_controller_clk_en   = doze_q;
        ebi_io_clk_en = doze_q;
      end
      SMC_SLEEP: begin
      end
      SMC_STOP: begin
        ls_osc_run        = 1'b0;
        keep_alive_clk_en = 1'b0;
        rtc_clk_en        = 1'b0;
        pin_drive_en      = drive_enable;
      end
      default: begin  // warm-up: only the low-speed oscillator, pin drive and, unless returning to SLOW, the high-speed oscillator stay on
        hs_osc_run        = !prev_slow_q;
        keep_alive_clk_en = 1'b0;
        rtc_clk_en        = 1'b0;
      end
    endcase
  end

  // bus ownership: refused in Halt and deeper modes
  assign dma_bus_grant = dma_bus_req &
                         (mode_q == SMC_NORMAL || mode_q == SMC_SLOW ||
                          (mode_q == SMC_IDLE && doze_q));

  assign resume_pulse = resume_q;
  assign take_irq     = take_q;

  // ==========================================================
  // AXI4-Lite slave
  // address and data taken independently, response after both
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    ctrl_d    = ctrl_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wdata_d  = s_axi_wdata[7:0];
      wstrb0_d = s_axi_wstrb[0];
    end
    // perform the write once both halves are held
    if (aw_hold_q && w_hold_q && !bvalid_q) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      if (awaddr_q == SMC_CTRL_OFFS) begin
        bresp_d = SMC_RESP_OKAY;
        if (wstrb0_q) begin
          ctrl_d = wdata_q;
        end
      end else if (awaddr_q == SMC_STATUS_OFFS) begin
        bresp_d = SMC_RESP_OKAY;  // read only, write ignored
      end else begin
        bresp_d = SMC_RESP_SLVERR;
      end
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // read path
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = SMC_RESP_OKAY;
      rdata_d  = '0;
      if (s_axi_araddr == SMC_CTRL_OFFS) begin
        rdata_d[7:0] = ctrl_q;
      end else if (s_axi_araddr == SMC_STATUS_OFFS) begin
        rdata_d[SMC_STAT_MODE_LSB +: 3] = mode_q;
        rdata_d[SMC_STAT_BUSY_BIT]      = wu_busy;
        rdata_d[SMC_STAT_PREV_BIT]      = prev_slow_q;
      end else begin
        rresp_d = SMC_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready  = !w_hold_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // ==========================================================
  // register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= SMC_CTRL_RESET;
      mode_q      <= SMC_NORMAL;
      prev_slow_q <= 1'b0;
      hs_off_q    <= 1'b0;
      doze_q      <= 1'b0;
      resume_q    <= 1'b0;
      take_q      <= 1'b0;
      aw_hold_q   <= 1'b0;
      w_hold_q    <= 1'b0;
      awaddr_q    <= 8'h00;
      wdata_q     <= 8'h00;
      wstrb0_q    <= 1'b0;
      bvalid_q    <= 1'b0;
      bresp_q     <= SMC_RESP_OKAY;
      rvalid_q    <= 1'b0;
      rresp_q     <= SMC_RESP_OKAY;
      rdata_q     <= 32'h00000000;
    end else begin
      ctrl_q      <= ctrl_d;
      mode_q      <= mode_d;
      prev_slow_q <= prev_slow_d;
      hs_off_q    <= hs_off_d;
      doze_q      <= doze_d;
      resume_q    <= resume_d;
      take_q      <= take_d;
      aw_hold_q   <= aw_hold_d;
      w_hold_q    <= w_hold_d;
      awaddr_q    <= awaddr_d;
      wdata_q     <= wdata_d;
      wstrb0_q    <= wstrb0_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      rvalid_q    <= rvalid_d;
      rresp_q     <= rresp_d;
      rdata_q     <= rdata_d;
    end
  end

endmodule

// ---- smc_pkg.sv ----
// standby mode controller: shared constants, register map and mode encodings
// assumes a 32-bit AXI4-Lite register port and one system clock
// Contract
// - SLOW: PLL off, CPU and limited peripherals clocked
// - SLEEP: low-speed oscillator and three blocks only
// - IDLE: CPU stopped; DMA runs; Doze keeps more
// - wake on interrupt above mask, or reset
// - level at or above mask: take interrupt
// - below mask: resume, request flag stays set; code wakes only above mask or on NMI
// - nonmaskable interrupt is always serviced after wake
// - reset releases every standby mode
// - pin and key wake of STOP waits warm-up
// - pulse counter interrupts wake SLEEP in counter mode
// - per-mode release sources for SLEEP and STOP
// - interrupts disabled: wake only when level exceeds mask
// - STOP halts everything including both oscillators
// - STOP pin drive follows drive-enable bit
// - system clock restarts after warm-up count
// - STOP returns to prior NORMAL or SLOW
// - warm-up on SLEEP/STOP exits and cold SLOW exit; SLEEP exit back to SLOW skips warm-up
// - two-bit type field, Halt/Doze by core bit
// - Halt refuses DMA bus requests, Doze grants
package smc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] SMC_CTRL_OFFS   = 8'h00;  // control, read/write
  localparam logic [7:0] SMC_STATUS_OFFS = 8'h04;  // status, read only

  // control field positions
  localparam int SMC_CTRL_TYPE_LSB = 0;  // standby_type_select, 2 bits
  localparam int SMC_CTRL_WU_LSB   = 2;  // warmup_select, 2 bits
  localparam int SMC_CTRL_HSEN_BIT = 4;  // hs_osc_enable
  localparam int SMC_CTRL_DRVE_BIT = 5;  // pin drive enable during STOP
  localparam int SMC_CTRL_SLOW_BIT = 6;  // request SLOW operating mode
  localparam int SMC_CTRL_PCNT_BIT = 7;  // pulse counter mode selected
  localparam logic [7:0] SMC_CTRL_RESET = 8'h10;  // oscillator on, all else 0

  // status field positions
  localparam int SMC_STAT_MODE_LSB = 0;  // current mode, 3 bits
  localparam int SMC_STAT_BUSY_BIT = 3;  // warm-up counting
  localparam int SMC_STAT_PREV_BIT = 4;  // return target is SLOW

  // standby type codes
  localparam logic [1:0] SMC_TYPE_RSVD  = 2'h0;
  localparam logic [1:0] SMC_TYPE_STOP  = 2'h1;
  localparam logic [1:0] SMC_TYPE_SLEEP = 2'h2;
  localparam logic [1:0] SMC_TYPE_IDLE  = 2'h3;

  // warm-up lengths in oscillator cycles; the longest fits here
  localparam int SMC_WU_CNT_W     = 17;
  localparam int SMC_WU_LEN_SHORT = 256;  // codes 00 and 01

  // bus answers
  localparam logic [1:0] SMC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SMC_RESP_SLVERR = 2'h2;

  // operating modes, Gray along normal-idle-sleep-stop-warmup-slow
  typedef enum logic [2:0] {
    SMC_NORMAL = 3'h0,
    SMC_IDLE   = 3'h1,
    SMC_SLEEP  = 3'h3,
    SMC_STOP   = 3'h2,
    SMC_WARMUP = 3'h6,
    SMC_SLOW   = 3'h4
  } smc_mode_t;

endpackage

// ---- smc_warmup.sv ----
// standby mode controller: oscillator warm-up counter
// assumes osc_tick is a one-cycle pulse per cycle of the restarted oscillator
`timescale 1ns/1ns
module smc_warmup #(
  parameter int LEN_MID  = 16384,
  parameter int LEN_LONG = 65536
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // control
  input  wire logic        start,
  input  wire logic [1:0]  sel,
  input  wire logic        osc_tick,
  // result
  output logic             busy,
  output logic             done
);
  import smc_pkg::*;

  logic [SMC_WU_CNT_W-1:0] cnt_q, cnt_d;    // remaining oscillator cycles
  logic                    busy_q, busy_d;  // counting
  logic                    done_q, done_d;  // one-cycle end pulse

  // length chosen by the two-bit code
  function automatic logic [SMC_WU_CNT_W-1:0] wu_len(input logic [1:0] s);
    case (s)
      2'h2:    wu_len = SMC_WU_CNT_W'(LEN_MID);
      2'h3:    wu_len = SMC_WU_CNT_W'(LEN_LONG);
      default: wu_len = SMC_WU_CNT_W'(SMC_WU_LEN_SHORT);
    endcase
  endfunction

  // ==========================================================
  // counter
  // load on start, step down on each oscillator tick
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d  = wu_len(sel);
      busy_d = 1'b1;
    end else if (busy_q && osc_tick) begin
      if (cnt_q == SMC_WU_CNT_W'(1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      cnt_d = cnt_q - SMC_WU_CNT_W'(1);
    end
  end

  // register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule

// ---- smc_core_model.sv ----
// standby controller far side: core wait pulse, level pin interrupt, oscillator ticks
// assumes one aclk domain shared with the controller
`timescale 1ns/1ns
module smc_core_model (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // requests from the bench
  input  wire logic go,
  input  wire logic pin_req,
  // controller answers
  input  wire logic resume_pulse,
  input  wire logic hs_osc_run,
  input  wire logic ls_osc_run,
  // toward the controller
  output logic      wait_exec,
  output logic      ext_pin_irqs,
  output logic      hs_osc_tick,
  output logic      ls_osc_tick
);
  logic [1:0] div_q = 2'h0;  // low-speed oscillator runs at a quarter rate
  initial begin
    {wait_exec, ext_pin_irqs, hs_osc_tick, ls_osc_tick} = 4'h0;
  end
  // ==========================================================
  // core and oscillators
  always @(posedge aclk) begin
    wait_exec   <= go & aresetn;
    hs_osc_tick <= hs_osc_run;
    div_q       <= div_q + 2'h1;
    ls_osc_tick <= ls_osc_run & (div_q == 2'h0);
    // pin level held until the core resumes
    if (!aresetn || resume_pulse) ext_pin_irqs <= 1'b0;
    else if (pin_req) ext_pin_irqs <= 1'b1;
  end
endmodule

// ---- smc_chk.sv ----
// standby controller checker: clock gating per mode, wake and take relations
// assumes binding to smc_top, one aclk domain
`timescale 1ns/1ns
module smc_chk #(
  parameter int WU_LEN_MID  = 16384,
  parameter int WU_LEN_LONG = 65536
) (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // core and interrupts
  input wire logic       nmi_req,
  input wire logic       cpu_irq_accept,
  input wire logic [7:0] irq_level,
  input wire logic [7:0] irq_mask_level,
  input wire logic       resume_pulse,
  input wire logic       take_irq,
  // dma
  input wire logic       dma_bus_req,
  input wire logic       dma_bus_grant,
  // clock generator
  input wire logic       hs_osc_run,
  input wire logic       ls_osc_run,
  input wire logic       pll_run,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       irq_controller_clk_en,
  input wire logic       ebi_io_clk_en,
  input wire logic       dma_clk_en,
  input wire logic       keep_alive_clk_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // stop and warm-up steps
  sequence s_stop; !ls_osc_run; endsequence
  sequence s_warm; ls_osc_run && !cpu_clk_en && !keep_alive_clk_en; endsequence
  property p_slow; cpu_clk_en && !pll_run |-> irq_controller_clk_en && ebi_io_clk_en
    && keep_alive_clk_en && !dma_clk_en && !periph_clk_en; endproperty
  property p_sleep; keep_alive_clk_en && !cpu_clk_en && !pll_run |-> ls_osc_run
    && !hs_osc_run && !irq_controller_clk_en && !dma_clk_en; endproperty
  property p_idle; pll_run && !cpu_clk_en |-> hs_osc_run && ls_osc_run && dma_clk_en
    && (irq_controller_clk_en == ebi_io_clk_en); endproperty
  property p_halt; dma_bus_grant |-> dma_bus_req && (cpu_clk_en || irq_controller_clk_en); endproperty
  property p_take; take_irq |-> resume_pulse
    && $past(nmi_req || (cpu_irq_accept && irq_level >= irq_mask_level)); endproperty
  property p_stop; s_stop |-> !hs_osc_run && !pll_run && !cpu_clk_en; endproperty
  property p_exit; s_stop ##1 ls_osc_run |-> s_warm; endproperty
  property p_rst; disable iff (1'b0) !aresetn |=> cpu_clk_en && pll_run; endproperty
  a_slow: assert property (p_slow) else $error("slow gating wrong");
  a_sleep: assert property (p_sleep) else $error("sleep gating wrong");
  a_idle: assert property (p_idle) else $error("idle gating wrong");
  a_halt: assert property (p_halt) else $error("grant in halt");
  a_take: assert property (p_take) else $error("take without cause");
  a_stop: assert property (p_stop) else $error("stop not halted");
  a_exit: assert property (p_exit) else $error("stop exit skips warmup");
  a_rst: assert property (p_rst) else $error("reset kept standby");
endmodule
bind smc_top smc_chk #(.WU_LEN_MID(WU_LEN_MID), .WU_LEN_LONG(WU_LEN_LONG)) u_chk (.*);

// ---- test_standby_mode_controller.sv ----
// standby controller bench: register access, each standby mode, wake sources
// assumes smc_pkg, smc_top, smc_core_model and the bound checker
`timescale 1ns/1ns
module test_standby_mode_controller;
  import smc_pkg::*;
  logic aclk = 0, aresetn = 0, go = 0, pin_req = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, irq_level = 0, irq_mask_level = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, reduced_power_select = 0, cpu_irq_accept = 0, nmi_req = 0;
  logic dma_bus_req = 0, wait_exec, ext_pin_irqs, hs_osc_tick, ls_osc_tick;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic resume_pulse, take_irq, dma_bus_grant, hs_osc_run, ls_osc_run, pll_run;
  logic cpu_clk_en, periph_clk_en, irq_controller_clk_en, ebi_io_clk_en, dma_clk_en;
  logic keep_alive_clk_en, rtc_clk_en, pin_drive_en;
  logic [7:0] src = 0;  // watchdog timer serial twowire converter pulse rtc key
  wire watchdog_irq = src[0], general_timer_irqs = src[1], serial_irq = src[2];
  wire two_wire_serial_irq = src[3], converter_irq = src[4];
  wire pulse_counter_irqs = src[5], rtc_irq = src[6], key_wakeup = src[7];
  wire [10:0] clks = {hs_osc_run, ls_osc_run, pll_run, cpu_clk_en, periph_clk_en,
    irq_controller_clk_en, ebi_io_clk_en, dma_clk_en, keep_alive_clk_en, rtc_clk_en, pin_drive_en};
  int fails = 0, tests_run = 0;
  smc_top #(.WU_LEN_MID(8), .WU_LEN_LONG(16)) dut (.*);
  smc_core_model model (.*);
  always #50 aclk = ~aclk;
  // ==========================================================
  // helpers
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task to(input logic d);
    if (!d) begin
      $display("mismatch wait exp done got hang");
      fails++;
      wrap_up;
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic dn;
    dn = 0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    for (int n = 0; n < 40 && !dn; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        dn = 1;
        chk("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
      end
    end
    to(dn);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic dn;
    dn = 0;
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    for (int n = 0; n < 40 && !dn; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        dn = 1;
        chk("rdata", d, s_axi_rdata);
        chk("rresp", {30'h0, e}, {30'h0, s_axi_rresp});
      end
    end
    to(dn);
  endtask
  task enter(input logic [7:0] c, input logic rp);
    wr(SMC_CTRL_OFFS, {24'h0, c}, SMC_RESP_OKAY);
    reduced_power_select <= rp; go <= 1;
    @(posedge aclk);
    go <= 0;
    tick(3);
  endtask
  task wake(input logic t);
    logic dn;
    dn = 0;
    for (int n = 0; n < 3000 && !dn; n++) begin
      @(posedge aclk);
      if (resume_pulse) begin
        dn = 1;
        chk("take", {31'h0, t}, {31'h0, take_irq});
      end
    end
    to(dn);
    tick(2);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    tick(2);
    aresetn <= 1;  // held two cycles
    tick(1);
    rd(SMC_CTRL_OFFS, 32'h10, SMC_RESP_OKAY);
    rd(8'h08, 32'h0, SMC_RESP_SLVERR);
    wr(8'h08, 32'h0, SMC_RESP_SLVERR);
    wr(SMC_STATUS_OFFS, 32'hFF, SMC_RESP_OKAY);
    rd(SMC_STATUS_OFFS, 32'h0, SMC_RESP_OKAY);
    $display("registers done");
    irq_mask_level <= 3; irq_level <= 3; cpu_irq_accept <= 1; dma_bus_req <= 1;
    enter(8'h13, 0);
    chk("clks", 11'h74F, clks);
    chk("grant", 0, dma_bus_grant);
    src <= 8'h02; tick(10);
    chk("clks", 11'h74F, clks);
    irq_level <= 5; wake(1);
    src <= 0; cpu_irq_accept <= 0; irq_level <= 3;
    enter(8'h13, 1);
    chk("grant", 1, dma_bus_grant);
    src <= 8'h10; tick(10);
    chk("clks", 11'h77F, clks);
    irq_level <= 5; wake(0);
    $display("idle done");
    src <= 0;
    enter(8'h12, 0);
    chk("clks", 11'h207, clks);
    for (int i = 0; i < 6; i++) begin
      src <= 8'h01 << i; tick(8);
      chk("clks", 11'h207, clks);
    end
    src <= 8'h40; tick(3);
    chk("clks", 11'h601, clks);
    wake(0);
    chk("clks", 11'h7FF, clks);
    src <= 0; enter(8'h9A, 0); src <= 8'h20; wake(0);
    src <= 0;
    enter(8'h39, 0);  // warm-up code 10
    chk("clks", 11'h001, clks);
    src <= 8'h40; tick(8);
    chk("clks", 11'h001, clks);
    src <= 0; nmi_req <= 1; wake(1);
    nmi_req <= 0;
    chk("clks", 11'h7FF, clks);
    $display("sleep and stop done");
    wr(SMC_CTRL_OFFS, 32'h60, SMC_RESP_OKAY);  // oscillator off
    tick(3);
    chk("clks", 11'h2B7, clks);
    enter(8'h6D, 0);
    pin_req <= 1;
    @(posedge aclk);
    pin_req <= 0; tick(4);
    chk("clks", 11'h201, clks);
    wake(0);
    chk("clks", 11'h2B7, clks);
    wr(SMC_CTRL_OFFS, 32'h18, SMC_RESP_OKAY); tick(3);
    chk("clks", 11'h601, clks);
    tick(20);
    chk("clks", 11'h7FF, clks);
    enter(8'h6D, 0);
    aresetn <= 0; tick(2);
    aresetn <= 1; tick(1);
    chk("clks", 11'h7FF, clks);
    $display("slow done");
    wrap_up;
  end
endmodule
